// ### can_abort_pkg.sv
// shared constants, types and the defective-clear timer
`timescale 1ns/10ps
package can_abort_pkg;
   // ==========================================================
   // mailboxes and bit timing
   localparam int         NUM_MBX        = 16;
   localparam int         CLK_PERIOD_NS  = 10;
   localparam int         TQ_NS          = 100;
   localparam int         TQ_CYCLES      = TQ_NS / CLK_PERIOD_NS;
   localparam logic [3:0] TQ_LAST        = 4'(TQ_CYCLES - 1);
   localparam logic [3:0] BIT_LAST       = 4'h9;
   localparam logic [3:0] SAMPLE_TQ      = 4'h7;
   localparam logic [3:0] JUMP_MAX_TQ    = 4'h4;
   localparam int         ERR_DELAY_TQ   = 5;
   // ==========================================================
   // frame shapes
   localparam logic [6:0] FRAME_BITS     = 7'h40;
   localparam logic [5:0] ERR_FLAG_LAST  = 6'h05;
   localparam logic [5:0] ERR_FRAME_LAST = 6'h0D;
   // ==========================================================
   // defective clear delay ((16 - mailbox) * 2) + 3
   localparam int         CLR_BASE       = 16;
   localparam int         CLR_MULT       = 2;
   localparam int         CLR_ADD        = 3;
   localparam logic [15:0] MBX_NONE      = 16'h0000;
   localparam logic [15:0] MBX_ONE       = 16'h0001;

   typedef struct packed {
      logic [15:0] request_set;
      logic [15:0] request_reset;
      logic [15:0] tx_ack;
      logic [15:0] abort_ack;
   } mbx_status_t;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h1,
      ST_TX        = 4'h2,
      ST_ERR       = 4'h4,
      ST_WRAP_IDLE = 4'h8
   } wrap_state_t;

   function automatic logic [5:0] clr_delay(input logic [3:0] mbx);
      clr_delay = 6'((CLR_BASE - int'(mbx)) * CLR_MULT + CLR_ADD);
   endfunction : clr_delay

   function automatic logic [3:0] lowest_set(input logic [15:0] v);
      lowest_set = 4'h0;
      for (int i = NUM_MBX - 1; i >= 0; i--)
         if (v[i])
            lowest_set = 4'(i);
   endfunction : lowest_set

   function automatic logic [15:0] mbx_bit(input logic [3:0] idx);
      mbx_bit = MBX_ONE << idx;
   endfunction : mbx_bit
endpackage : can_abort_pkg

module abort_clear_timer
   import can_abort_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       clk_en_i,
   input  wire logic       start_i,
   input  wire logic [3:0] mbx_i,
   output logic            busy_o,
   output logic            done_o,
   output logic [3:0]      mbx_o
);
   logic [5:0] cnt;

   assign done_o = busy_o & (cnt == 6'h00);

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt    <= 6'h00;
         busy_o <= 1'b0;
         mbx_o  <= 4'h0;
      end
      else if (clk_en_i)
      begin
         if (start_i)
         begin
            cnt    <= clr_delay(mbx_i) - 6'h01;
            busy_o <= 1'b1;
            mbx_o  <= mbx_i;
         end
         else if (done_o)
            busy_o <= 1'b0;
         else if (busy_o)
            cnt <= cnt - 6'h01;
      end
   end
endmodule : abort_clear_timer

// ### can_bus_node_model.sv
// bus transceiver and far nodes as seen from the receive pin
`timescale 1ns/10ps
module can_bus_node_model
(
   input  wire logic can_transmit_i,
   input  wire logic self_test_i,
   input  wire logic force_dom_i,
   input  wire logic force_rec_i,
   output logic      can_receive_pin_o
);
   // ==========================================================
   // wired-and bus; a forced level stands for another node or a fault
   // self-test: pin held high, no bus traffic at all
   assign can_receive_pin_o = self_test_i ? 1'b1 :
                              force_dom_i ? 1'b0 : (force_rec_i | can_transmit_i);
endmodule : can_bus_node_model

// ### can_tx_abort_and_resync.sv
// transmit engine with abort handling, error frames and resync quirk
// Notes on behaviour
// - transmitter seeing its dominant bit read recessive starts error frame next bit
// - after that error, late edges skip resync; delay at most two quanta
// - after request-reset clears, normally tx or abort acknowledge gets set
// - fault, pending request, reset in wrap idle: silent clear after delay
// - reset write one cycle off the idle slot behaves normally
`timescale 1ns/10ps
module can_tx_abort_and_resync
   import can_abort_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        clk_en_i,
   input  wire logic [15:0] tx_request_set_i,
   input  wire logic [15:0] tx_request_reset_i,
   input  wire logic [15:0] tx_ack_clr_i,
   input  wire logic [15:0] abort_ack_clr_i,
   input  wire logic        self_test_i,
   input  wire logic [63:0] frame_bits_i,
   input  wire logic        can_receive_pin_i,
   output mbx_status_t      status_o,
   output logic [3:0]       cur_mbx_o,
   output logic             can_transmit_o,
   output logic             bus_busy_o
);
   // ==========================================================
   // receive synchroniser and edge detect
   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   wire  rx_eff  = self_test_i ? (can_transmit_o & rx_sync) : rx_sync;
   wire  rx_fall = rx_prev & ~rx_eff;

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end
      else if (clk_en_i)
      begin
         rx_meta <= can_receive_pin_i;
         rx_sync <= rx_meta;
         rx_prev <= rx_eff;
      end
   end

   // ==========================================================
   // bit timing
   logic [3:0]  presc;
   logic [3:0]  tq_cnt;
   logic [3:0]  next_tq_cnt;
   wrap_state_t state;
   wrap_state_t next_state;
   logic        err_pending;
   wire         tq_tick      = (presc == TQ_LAST);
   wire         bit_start    = tq_tick & (tq_cnt == BIT_LAST);
   wire         sample_pt    = tq_tick & (tq_cnt == SAMPLE_TQ);
   wire         after_sample = (tq_cnt > SAMPLE_TQ);
   wire  [3:0]  jump_tq      = tq_cnt + JUMP_MAX_TQ;
   // a late edge after a bit error is ignored, which delays the error frame
   wire         resync_jump  = (state == ST_TX) & rx_fall & after_sample
                               & ~err_pending & ~tq_tick;

   always_comb
   begin
      next_tq_cnt = tq_cnt;
      if (resync_jump)
         next_tq_cnt = (jump_tq > BIT_LAST) ? BIT_LAST : jump_tq;
      else if (tq_tick)
         next_tq_cnt = (tq_cnt == BIT_LAST) ? 4'h0 : tq_cnt + 4'h1;
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         presc  <= 4'h0;
         tq_cnt <= 4'h0;
      end
      else if (clk_en_i)
      begin
         presc  <= tq_tick ? 4'h0 : presc + 4'h1;
         tq_cnt <= next_tq_cnt;
      end
   end

   // ==========================================================
   // mailbox flags and selection
   logic [15:0] pend;
   logic [15:0] cancel;
   logic [15:0] sent;
   logic [15:0] voided;
   logic        timer_busy;
   logic        timer_done;
   logic [3:0]  timer_mbx;
   logic        last_fault;
   logic [6:0]  bit_idx;
   logic [6:0]  next_bit_idx;
   logic        next_tx_bit;
   logic        next_err_pending;
   logic        next_last_fault;
   logic        frame_ok;
   logic        lost_arb;

   wire  [15:0] lock_mask   = timer_busy ? mbx_bit(timer_mbx) : MBX_NONE;
   wire  [15:0] hold_mask   = ((state == ST_TX) | (state == ST_ERR))
                              ? mbx_bit(cur_mbx_o) : MBX_NONE;
   wire  [15:0] ready_mask  = pend & ~cancel & ~lock_mask;
   wire  [3:0]  pick_mbx    = lowest_set(ready_mask);
   wire  [15:0] abort_mask  = cancel & ~hold_mask & ~lock_mask;
   wire  [15:0] done_mask   = frame_ok ? mbx_bit(cur_mbx_o) : MBX_NONE;
   wire  [15:0] defect_clr  = timer_done ? mbx_bit(timer_mbx) : MBX_NONE;
   wire  [15:0] pend_now    = pend | tx_request_set_i;
   wire  [15:0] defect_cand = tx_request_reset_i & pend_now;
   // the silent clear only arms in the single wrap idle slot
   wire         defect_go   = (state == ST_WRAP_IDLE) & last_fault
                              & (|defect_cand) & ~timer_busy;
   wire  [15:0] req_clr     = done_mask | abort_mask | defect_clr;
   wire  [15:0] next_pend   = (pend & ~req_clr) | tx_request_set_i;
   wire  [15:0] next_cancel = (cancel & ~req_clr) | tx_request_reset_i;
   // set wins over a software clear in the same cycle
   wire  [15:0] next_sent   = (sent & ~tx_ack_clr_i) | done_mask;
   wire  [15:0] next_voided = (voided & ~abort_ack_clr_i) | abort_mask;
   wire  [15:0] ack_any     = sent | voided;

   abort_clear_timer u_clr_timer (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .clk_en_i   (clk_en_i),
      .start_i    (defect_go),
      .mbx_i      (lowest_set(defect_cand)),
      .busy_o     (timer_busy),
      .done_o     (timer_done),
      .mbx_o      (timer_mbx)
   );

   // ==========================================================
   // transmit state machine
   always_comb
   begin
      next_state       = state;
      next_bit_idx     = bit_idx;
      next_tx_bit      = can_transmit_o;
      next_err_pending = err_pending;
      next_last_fault  = last_fault;
      frame_ok         = 1'b0;
      lost_arb         = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (bit_start & (|ready_mask))
            begin
               next_state   = ST_TX;
               next_bit_idx = 7'h00;
               next_tx_bit  = 1'b1;
            end
         end
         ST_TX:
         begin
            if (sample_pt & (bit_idx != 7'h00) & ~can_transmit_o & rx_eff)
               next_err_pending = 1'b1;
            else if (sample_pt & (bit_idx != 7'h00) & can_transmit_o & ~rx_eff)
            begin
               lost_arb        = 1'b1;
               next_state      = ST_WRAP_IDLE;
               next_tx_bit     = 1'b1;
               next_last_fault = 1'b1;
            end
            else if (bit_start & err_pending)
            begin
               next_state       = ST_ERR;
               next_bit_idx     = 7'h00;
               next_tx_bit      = 1'b0;
               next_err_pending = 1'b0;
               next_last_fault  = 1'b1;
            end
            else if (bit_start & (bit_idx == FRAME_BITS))
            begin
               frame_ok        = 1'b1;
               next_state      = ST_WRAP_IDLE;
               next_tx_bit     = 1'b1;
               next_last_fault = 1'b0;
            end
            else if (bit_start)
            begin
               next_tx_bit  = frame_bits_i[~bit_idx[5:0]];
               next_bit_idx = bit_idx + 7'h01;
            end
         end
         ST_ERR:
         begin
            if (bit_start & (bit_idx[5:0] == ERR_FRAME_LAST))
            begin
               next_state  = ST_WRAP_IDLE;
               next_tx_bit = 1'b1;
            end
            else if (bit_start)
            begin
               next_bit_idx = bit_idx + 7'h01;
               next_tx_bit  = (bit_idx[5:0] >= ERR_FLAG_LAST);
            end
         end
         ST_WRAP_IDLE:
            next_state = ST_IDLE;
         default:
         begin
            next_state  = ST_IDLE;
            next_tx_bit = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state          <= ST_IDLE;
         bit_idx        <= 7'h00;
         can_transmit_o <= 1'b1;
         err_pending    <= 1'b0;
         last_fault     <= 1'b0;
         cur_mbx_o      <= 4'h0;
      end
      else if (clk_en_i)
      begin
         state          <= next_state;
         bit_idx        <= next_bit_idx;
         can_transmit_o <= next_tx_bit;
         err_pending    <= next_err_pending;
         last_fault     <= next_last_fault;
         if ((state == ST_IDLE) & (next_state == ST_TX))
            cur_mbx_o <= pick_mbx;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pend       <= 16'h0000;
         cancel     <= 16'h0000;
         sent       <= 16'h0000;
         voided     <= 16'h0000;
         bus_busy_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         pend       <= next_pend;
         cancel     <= next_cancel;
         sent       <= next_sent;
         voided     <= next_voided;
         bus_busy_o <= (next_state != ST_IDLE);
      end
   end

   assign status_o = '{request_set: pend, request_reset: cancel,
                       tx_ack: sent, abort_ack: voided};

   // ==========================================================
   // checks; helper counters only feed assertions
   localparam int ERR_WAIT_MAX = (int'(BIT_LAST) - int'(SAMPLE_TQ)) * TQ_CYCLES;
   logic [7:0] err_wait;
   logic [5:0] defect_age;
   wire  [15:0] norm_clr = cancel & ~next_cancel & ~defect_clr;

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         err_wait   <= 8'h00;
         defect_age <= 6'h00;
      end
      else if (clk_en_i)
      begin
         err_wait   <= err_pending ? err_wait + 8'h01 : 8'h00;
         defect_age <= defect_go ? 6'h01 : defect_age + 6'h01;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i || !clk_en_i);

   err_frame_start_a: assert property (err_pending && bit_start && state == ST_TX
      |=> state == ST_ERR && !can_transmit_o) else $error("error frame not started");
   bit_err_seen_a: assert property (state == ST_TX && sample_pt && bit_idx != 7'h00
      && !can_transmit_o && rx_eff |=> err_pending) else $error("bit error missed");
   err_delay_bound_a: assert property (err_pending |-> err_wait <= 8'(ERR_WAIT_MAX))
      else $error("error frame delayed too long");
   normal_ack_a: assert property ((|norm_clr)
      |=> ((ack_any & $past(norm_clr)) == $past(norm_clr))) else $error("abort without ack");
   defect_delay_a: assert property (timer_done
      |-> defect_age == clr_delay(timer_mbx)) else $error("silent clear delay wrong");
   defect_no_ack_a: assert property ((|defect_clr) |=> (((pend | cancel) & $past(defect_clr)) == 0)
      && ((ack_any & ~$past(ack_any) & $past(defect_clr)) == 0)) else $error("silent clear bad");
   defect_slot_a: assert property (defect_go |-> state == ST_WRAP_IDLE
      ##1 state == ST_IDLE) else $error("silent clear outside idle slot");
   tx_done_ack_a: assert property ((|done_mask) && !(|(tx_request_set_i & done_mask))
      |=> ((sent & $past(done_mask)) != 0) && ((pend & $past(done_mask)) == 0))
      else $error("sent message not acknowledged");
   lost_arb_retry_a: assert property (lost_arb |=> state == ST_WRAP_IDLE
      ##1 state == ST_IDLE) else $error("no retry after lost arbitration");

   frame_ok_c: cover property (frame_ok);
   err_frame_c: cover property (state == ST_TX ##1 state == ST_ERR);
   abort_c: cover property (|(abort_mask & pend));
   defect_c: cover property (defect_go ##[1:40] timer_done);
endmodule : can_tx_abort_and_resync

// ### tb_top.sv
// self-checking bench for abort handling, error frames and silent clear
`timescale 1ns/10ps
module tb_top
   import can_abort_pkg::*;
   ;
   // ==========================================================
   // signals
   localparam int CLR_M3 = ((16 - 3) * 2) + 3;
   logic        core_clk_i;
   logic        rst_b_i;
   logic [15:0] req_set;
   logic [15:0] req_rst;
   logic [15:0] sent_clr;
   logic [15:0] void_clr;
   logic        self_test;
   logic [63:0] frame;
   logic        rx_pin;
   logic        force_dom;
   logic        force_rec;
   mbx_status_t st;
   logic [3:0]  cur_mbx;
   logic        tx_line;
   logic        busy;
   int          n_mismatch;
   int          comparisons;
   int          fall;
   int          nsil;
   int          sil_n;

   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   can_tx_abort_and_resync u_dut (
      .core_clk_i         (core_clk_i),
      .rst_b_i            (rst_b_i),
      .clk_en_i           (1'b1),
      .tx_request_set_i   (req_set),
      .tx_request_reset_i (req_rst),
      .tx_ack_clr_i       (sent_clr),
      .abort_ack_clr_i    (void_clr),
      .self_test_i        (self_test),
      .frame_bits_i       (frame),
      .can_receive_pin_i  (rx_pin),
      .status_o           (st),
      .cur_mbx_o          (cur_mbx),
      .can_transmit_o     (tx_line),
      .bus_busy_o         (busy)
   );

   can_bus_node_model u_bus (
      .can_transmit_i    (tx_line),
      .self_test_i       (self_test),
      .force_dom_i       (force_dom),
      .force_rec_i       (force_rec),
      .can_receive_pin_o (rx_pin)
   );

   // ==========================================================
   // tasks
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cyc

   task automatic do_reset(input int n);
      @(negedge core_clk_i);
      rst_b_i <= 1'b0;
      self_test <= 1'b0;
      cyc(n);
      rst_b_i <= 1'b1;
   endtask : do_reset

   task automatic set_req(input logic [3:0] m);
      @(negedge core_clk_i);
      req_set <= 16'h0001 << m;
      @(negedge core_clk_i);
      req_set <= 16'h0000;
   endtask : set_req

   // bounded wait for the engine to start a frame
   task automatic wait_busy;
      int i;
      for (i = 0; i < 400 && busy !== 1'b1; i++)
         cyc(1);
      check("busy rise", busy, 1'b1);
      if (busy !== 1'b1)
         wrap_up();
   endtask : wait_busy

   // abort pulse at cycle n; fall = edges from pulse edge to reset bit clear
   // arb: bus held dominant over bits one and two, so arbitration is lost at bit two
   task automatic abort_run(input int n, input logic [3:0] m, input bit arb, output int f);
      int c;
      bit seen;
      f = 0;
      seen = 0;
      if (arb)
         wait_busy();
      for (c = 0; c < 340; c++)
      begin
         @(negedge core_clk_i);
         force_dom <= arb && c >= 120 && c < 285;
         req_rst <= (c == n) ? (16'h0001 << m) : 16'h0000;
         if (st.request_reset[m] === 1'b1)
            seen = 1;
         else if (seen && f == 0)
            f = c - n - 1;
      end
   endtask : abort_run

   task automatic tx_frame(input logic [3:0] m, input logic stm);
      int p;
      self_test <= stm;
      frame <= 64'hA5F0_3C96_0FF0_1234;
      set_req(m);
      wait_busy();
      check("pending", st.request_set[m], 1'b1);
      check("cur_mbx", cur_mbx, m);
      // lead-in bit, then msb first, one bit per 100 cycles
      for (p = 0; p <= 64; p++)
      begin
         cyc(50);
         check("tx bit", tx_line, (p == 0) ? 1'b1 : frame[64 - p]);
         cyc(50);
      end
      cyc(10);
      check("tx_ack", st.tx_ack[m], 1'b1);
      check("sent req", st.request_set[m], 1'b0);
      sent_clr <= 16'h0001 << m;
      cyc(1);
      sent_clr <= 16'h0000;
      cyc(2);
      check("tx_ack clr", st.tx_ack[m], 1'b0);
      check("busy end", busy, 1'b0);
      check("line idle", tx_line, 1'b1);
   endtask : tx_frame

   // dominant bit read back recessive, then a late edge in the same bit
   task automatic err_frame;
      int c;
      self_test <= 1'b0;
      frame <= 64'h7FFF_FFFF_FFFF_FFFF;
      set_req(4'h1);
      wait_busy();
      for (c = 0; c < 900; c++)
      begin
         @(negedge core_clk_i);
         force_rec <= c >= 120 && c < 188;
         if (c % 100 == 60 && c >= 200)
            check("error flag", tx_line, (c < 800) ? 1'b0 : 1'b1);
      end
   endtask : err_frame

   // ==========================================================
   // main sequence
   initial
   begin
      rst_b_i = 1'b0;
      req_set = 16'h0000;
      req_rst = 16'h0000;
      sent_clr = 16'h0000;
      void_clr = 16'h0000;
      self_test = 1'b0;
      frame = 64'h0;
      force_dom = 1'b0;
      force_rec = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      cyc(20);
      rst_b_i <= 1'b1;
      cyc(1);
      check("reset status", st, 64'h0);
      check("reset line", tx_line, 1'b1);
      check("reset busy", busy, 1'b0);
      $display("test reset done");
      abort_run(5, 4'h5, 1'b0, fall);
      check("idle abort fall", fall, 1);
      check("idle abort ack", st.abort_ack, 16'h0020);
      void_clr <= 16'h0020;
      cyc(1);
      void_clr <= 16'h0000;
      cyc(2);
      check("abort_ack clr", st.abort_ack, 16'h0000);
      $display("test idle abort done");
      tx_frame(4'h2, 1'b0);
      tx_frame(4'h3, 1'b1);
      $display("test frames done");
      err_frame();
      $display("test error frame done");
      // sweep the abort write across the wrap-idle slot
      nsil = 0;
      sil_n = 0;
      for (int n = 255; n <= 295; n++)
      begin
         do_reset(2);
         set_req(4'h3);
         abort_run(n, 4'h3, 1'b1, fall);
         if (st.tx_ack[3] === 1'b0 && st.abort_ack[3] === 1'b0)
         begin
            nsil++;
            sil_n = n;
            check("silent fall", fall, CLR_M3);
            check("silent req", st.request_set[3], 1'b0);
         end
         else
            check("abort ack", st.abort_ack[3], 1'b1);
      end
      check("silent count", nsil, 1);
      check("silent inside", sil_n > 255 && sil_n < 295, 1'b1);
      $display("test silent clear done");
      wrap_up();
   end
endmodule : tb_top
